// >>> pkg/muldiv_consts.svh
// Register addresses, field positions, reset values and timing counts
`ifndef MULDIV_CONSTS_SVH
`define MULDIV_CONSTS_SVH
`define MD_ADDR_OPERAND_0 8'he9
`define MD_ADDR_OPERAND_1 8'hea
`define MD_ADDR_OPERAND_2 8'heb
`define MD_ADDR_OPERAND_3 8'hec
`define MD_ADDR_OPERAND_4 8'hed
`define MD_ADDR_OPERAND_5 8'hee
`define MD_ADDR_CONTROL 8'hef
`define MD_CTRL_RESET 8'h00
`define MD_BIT_ERROR 7
`define MD_BIT_OVERFLOW 6
`define MD_BIT_RIGHT 5
`define MD_COUNT_MSB 4
`define MD_DIV32_CYCLES 6'h20
`define MD_DIV16_CYCLES 6'h10
`define MD_MUL_CYCLES 6'h02
`endif

// >>> pkg/muldiv_pkg.sv
// Types shared by the multiply/divide unit
`default_nettype none
package muldiv_pkg;
  typedef enum logic [2:0] {
    op_none,
    op_div32,
    op_div16,
    op_mul,
    op_shift,
    op_norm
  } op_t;

  // Special function register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage : muldiv_pkg
`default_nettype wire

// >>> core/muldiv_unit.sv
// Multiply/divide co-processor on the special function register bus
//
// Behaviour
// - Operand write order selects the operation
// - Restarting a running operation sets error flag
// - Overflow during operation sets overflow flag
// - Direction bit zero left, one right
// - Zero shift count selects normalize
// - Normalize leaves performed shift count
// - Nonzero shift count selects shift
// - Shift exactly the written count times
// - Divide 32/16, 16/16, multiply, shift, normalize
// - All arithmetic unsigned
// - Results overwrite operand registers
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_consts.svh"

module muldiv_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire muldiv_pkg::sfr_req_t req,
  output logic [7:0] rdata,
  // Status
  output logic busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] operand [0:5];
  logic error_flag;
  logic overflow_flag;
  logic shift_right;
  logic [4:0] shift_count;
  logic [2:0] load_step;
  logic [2:0] last_index;
  muldiv_pkg::op_t pending;
  muldiv_pkg::op_t op;
  logic [5:0] cycles;
  logic [4:0] shifts_left;
  logic [4:0] norm_done;
  logic [31:0] acc;
  logic [15:0] divisor;
  logic [16:0] rem;

  logic is_wr;
  logic [2:0] wr_index;
  logic wr_operand;
  logic wr_control;
  logic start;
  muldiv_pkg::op_t start_op;
  logic [16:0] trial;
  logic [31:0] product;

  assign is_wr = req.wr;
  assign wr_operand = is_wr && req.addr >= `MD_ADDR_OPERAND_0
                      && req.addr <= `MD_ADDR_OPERAND_5;
  assign wr_control = is_wr && req.addr == `MD_ADDR_CONTROL;
  assign wr_index = 3'(req.addr - `MD_ADDR_OPERAND_0);
  assign trial = {rem[15:0], acc[31]} - {1'b0, divisor};
  assign product = operand[1] == 8'h00 && operand[0] == 8'h00 ? 32'h0 :
                   {16'h0, operand[1], operand[0]} * {16'h0, operand[5], operand[4]};

  // ----------------------------------------------------------------
  // Operation decode from write order
  // ----------------------------------------------------------------
  // Order: 0,1,2,3,4,5 div32; 0,1,4,5 div16; 0,4,1,5 mul; 0..3 + control shift, or normalize with zero count
  always_comb begin
    start = 1'b0;
    start_op = muldiv_pkg::op_none;
    if (wr_operand && wr_index == 3'd5) begin
      start = 1'b1;
      if (pending == muldiv_pkg::op_div32 && last_index == 3'd4) begin
        start_op = muldiv_pkg::op_div32;
      end else if (pending == muldiv_pkg::op_mul && last_index == 3'd1) begin
        start_op = muldiv_pkg::op_mul;
      end else begin
        start_op = muldiv_pkg::op_div16;
      end
    end else if (wr_control) begin
      start = 1'b1;
      start_op = req.wdata[`MD_COUNT_MSB:0] == 5'h00 ? muldiv_pkg::op_norm
                                                 : muldiv_pkg::op_shift;
    end
  end

  // Track the write sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      load_step <= 3'd0;
      last_index <= 3'd0;
      pending <= muldiv_pkg::op_none;
    end else if (wr_operand) begin
      last_index <= wr_index;
      if (wr_index == 3'd0) begin
        load_step <= 3'd1;
        pending <= muldiv_pkg::op_div16;
      end else begin
        load_step <= load_step + 3'd1;
        if (load_step == 3'd1 && wr_index == 3'd4) begin
          pending <= muldiv_pkg::op_mul;
        end else if (load_step == 3'd2 && wr_index == 3'd2) begin
          pending <= muldiv_pkg::op_div32;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control/status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      error_flag <= 1'b0;
      shift_right <= 1'b0;
    end else begin
      if (wr_control) begin
        shift_right <= req.wdata[`MD_BIT_RIGHT];
      end
      if (start && busy) begin
        error_flag <= 1'b1;
      end else if (wr_control) begin
        error_flag <= req.wdata[`MD_BIT_ERROR];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and datapath
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      op <= muldiv_pkg::op_none;
      cycles <= 6'h00;
      shifts_left <= 5'h00;
      norm_done <= 5'h00;
      shift_count <= 5'h00;
      overflow_flag <= 1'b0;
      acc <= 32'h0;
      divisor <= 16'h0;
      rem <= 17'h0;
      for (int i = 0; i < 6; i++) begin
        operand[i] <= 8'h00;
      end
    end else if (start) begin
      busy <= 1'b1;
      op <= start_op;
      rem <= 17'h0;
      norm_done <= 5'h00;
      overflow_flag <= 1'b0;
      if (wr_control) begin
        shift_count <= req.wdata[`MD_COUNT_MSB:0];
        shifts_left <= req.wdata[`MD_COUNT_MSB:0];
        acc <= {operand[3], operand[2], operand[1], operand[0]};
      end else begin
        operand[5] <= req.wdata;
        unique case (start_op)
          muldiv_pkg::op_div32: begin
            acc <= {operand[3], operand[2], operand[1], operand[0]};
            divisor <= {req.wdata, operand[4]};
            cycles <= `MD_DIV32_CYCLES;
            overflow_flag <= {req.wdata, operand[4]} == 16'h0;
          end
          muldiv_pkg::op_div16: begin
            acc <= {operand[1], operand[0], 16'h0};
            divisor <= {req.wdata, operand[4]};
            cycles <= `MD_DIV16_CYCLES;
            overflow_flag <= {req.wdata, operand[4]} == 16'h0;
          end
          default: begin
            acc <= {operand[1], operand[0], 16'h0};
            divisor <= {req.wdata, operand[4]};
            cycles <= `MD_MUL_CYCLES;
          end
        endcase
      end
    end else if (wr_operand) begin
      operand[wr_index] <= req.wdata;
    end else if (busy) begin
      unique case (op)
        muldiv_pkg::op_div32, muldiv_pkg::op_div16: begin
          if (!trial[16]) begin
            rem <= trial;
            acc <= {acc[30:0], 1'b1};
          end else begin
            rem <= {rem[15:0], acc[31]};
            acc <= {acc[30:0], 1'b0};
          end
          cycles <= cycles - 6'h01;
          if (cycles == 6'h01) begin
            busy <= 1'b0;
            // Quotient in low operands, remainder in operand 4/5
            if (op == muldiv_pkg::op_div32) begin
              {operand[3], operand[2], operand[1], operand[0]} <=
                {acc[30:0], !trial[16]};
            end else begin
              {operand[1], operand[0]} <= {acc[14:0], !trial[16]};
            end
            {operand[5], operand[4]} <= !trial[16] ? trial[15:0] : {rem[14:0], acc[31]};
          end
        end
        muldiv_pkg::op_mul: begin
          cycles <= cycles - 6'h01;
          if (cycles == 6'h01) begin
            busy <= 1'b0;
            {operand[3], operand[2], operand[1], operand[0]} <=
              {product[31:16], product[15:0]};
            overflow_flag <= product[31:16] != 16'h0;
          end
        end
        muldiv_pkg::op_shift: begin
          if (shifts_left == 5'h00) begin
            busy <= 1'b0;
            {operand[3], operand[2], operand[1], operand[0]} <= acc;
          end else begin
            shifts_left <= shifts_left - 5'h01;
            acc <= shift_right ? {1'b0, acc[31:1]} : {acc[30:0], 1'b0};
          end
        end
        muldiv_pkg::op_norm: begin
          if (acc == 32'h0 || acc[31]) begin
            busy <= 1'b0;
            shift_count <= norm_done;
            overflow_flag <= acc == 32'h0;
            {operand[3], operand[2], operand[1], operand[0]} <= acc;
          end else begin
            acc <= {acc[30:0], 1'b0};
            norm_done <= norm_done + 5'h01;
          end
        end
        default: begin
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == `MD_ADDR_CONTROL) begin
        rdata <= {error_flag, overflow_flag, shift_right, shift_count};
      end else if (req.addr >= `MD_ADDR_OPERAND_0 && req.addr <= `MD_ADDR_OPERAND_5) begin
        rdata <= operand[3'(req.addr - `MD_ADDR_OPERAND_0)];
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_restart_error;
    @(posedge clk) disable iff (rst) (start && busy) |=> error_flag;
  endproperty
  a_restart_error: assert property (p_restart_error) else $error("restart lost error");

  property p_div_zero_ovf;
    @(posedge clk) disable iff (rst)
      (start && start_op == muldiv_pkg::op_div16 && {req.wdata, operand[4]} == 16'h0)
      |=> overflow_flag;
  endproperty
  a_div_zero_ovf: assert property (p_div_zero_ovf) else $error("no divide overflow");

  property p_norm_select;
    @(posedge clk) disable iff (rst)
      (wr_control && req.wdata[4:0] == 5'h00) |=> op == muldiv_pkg::op_norm;
  endproperty
  a_norm_select: assert property (p_norm_select) else $error("normalize not chosen");

  property p_shift_select;
    @(posedge clk) disable iff (rst)
      (wr_control && req.wdata[4:0] != 5'h00) |=> op == muldiv_pkg::op_shift && busy;
  endproperty
  a_shift_select: assert property (p_shift_select) else $error("shift not chosen");

  property p_shift_one;
    @(posedge clk) disable iff (rst)
      (wr_control && req.wdata == 8'h21 && !busy) ##1 (!start && !wr_operand) [*2]
      |=> !busy;
  endproperty
  a_shift_one: assert property (p_shift_one) else $error("shift length wrong");

  property p_norm_count;
    @(posedge clk) disable iff (rst)
      (busy && op == muldiv_pkg::op_norm && acc[31] && !start && !wr_operand)
      |=> shift_count == $past(norm_done);
  endproperty
  a_norm_count: assert property (p_norm_count) else $error("normalize count lost");

  property p_mul_result;
    @(posedge clk) disable iff (rst)
      (busy && op == muldiv_pkg::op_mul && cycles == 6'h01 && !start && !wr_operand)
      |=> {operand[3], operand[2], operand[1], operand[0]} == $past(product) && !busy;
  endproperty
  a_mul_result: assert property (p_mul_result) else $error("product not stored");

  property p_mul_order;
    @(posedge clk) disable iff (rst)
      (start && pending == muldiv_pkg::op_mul && last_index == 3'd1 && wr_operand)
      |=> op == muldiv_pkg::op_mul;
  endproperty
  a_mul_order: assert property (p_mul_order) else $error("order decode wrong");

  property p_left_shift;
    @(posedge clk) disable iff (rst)
      (busy && op == muldiv_pkg::op_shift && shifts_left != 5'h00 && !shift_right
       && !start && !wr_operand)
      |=> acc == ($past(acc) << 1);
  endproperty
  a_left_shift: assert property (p_left_shift) else $error("left shift wrong");

endmodule : muldiv_unit
`default_nettype wire

// >>> tb/muldiv_core_model.sv
// Core-side bus master model for the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module muldiv_core_model (
  // Clock
  input wire logic clk,
  // Register bus
  output var muldiv_pkg::sfr_req_t req,
  input wire logic [7:0] rdata
);
  // ----------------
  // Bus tasks
  // ----------------
  // Idle bus at time zero
  initial begin
    req = '0;
  end

  // One-cycle write strobe; released lines show inverted last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = {1'b1, 1'b0, a, d};
    @(posedge clk);
    #1;
    req = {1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // Read strobe; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    req = {1'b0, 1'b1, a, 8'h5a};
    @(posedge clk);
    #1;
    req = {1'b0, 1'b0, ~a, 8'ha5};
    v = rdata;
  endtask : rd
endmodule : muldiv_core_model
`default_nettype wire

// >>> tb/muldiv_coprocessor_sfr_tb.sv
// Self-checking testbench for the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_consts.svh"
module muldiv_coprocessor_sfr_tb;
  logic clk;
  logic rst;
  muldiv_pkg::sfr_req_t req;
  logic [7:0] rdata;
  logic busy;
  int bad_count;
  int n_tests;
  // Shift and normalize cases: operand, control, result
  localparam logic [0:5][31:0] sh_in = {32'h1, 32'h12345678, 32'h80000001, 32'h3, 32'h2,
                                        32'h1000};
  localparam logic [0:5][7:0] sh_ctl = {8'h04, 8'h28, 8'h3f, 8'h1f, 8'h21, 8'h00};
  localparam logic [0:5][31:0] sh_out = {32'h10, 32'h123456, 32'h1, 32'h80000000, 32'h1,
                                         32'h80000000};

  muldiv_unit dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .busy(busy));
  muldiv_core_model core (.clk(clk), .req(req), .rdata(rdata));

  // ----------------
  // Helpers
  // ----------------
  // Clock at 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Load 32-bit operand, low byte first
  task automatic ld(input logic [31:0] v);
    for (int i = 0; i < 4; i++) core.wr(`MD_ADDR_OPERAND_0 + i[7:0], v[8*i +: 8]);
  endtask : ld

  task automatic rd32(output logic [31:0] v);
    for (int i = 0; i < 4; i++) core.rd(`MD_ADDR_OPERAND_0 + i[7:0], v[8*i +: 8]);
  endtask : rd32

  // Bounded wait for the unit to go idle
  task automatic wait_done;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask : wait_done

  task automatic results;
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Watchdog
  initial begin
    #200000;
    bad_count++;
    results();
  end

  // ----------------
  // Test sequence
  // ----------------
  initial begin
    logic [31:0] v;
    logic [7:0] b;
    logic [7:0] h;
    bad_count = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    core.rd(`MD_ADDR_CONTROL, b);
    chk("control reset", 32'h0, {24'h0, b});
    core.rd(8'he8, b);
    chk("unmapped read", 32'h0, {24'h0, b});
    // Multiply: order 0,4,1,5
    core.wr(`MD_ADDR_OPERAND_0, 8'h34);
    core.wr(`MD_ADDR_OPERAND_4, 8'h78);
    core.wr(`MD_ADDR_OPERAND_1, 8'h12);
    core.wr(`MD_ADDR_OPERAND_5, 8'h56);
    wait_done();
    rd32(v);
    chk("product", 32'h06260060, v);
    core.rd(`MD_ADDR_CONTROL, b);
    chk("overflow mul", 32'h1, {31'h0, b[`MD_BIT_OVERFLOW]});
    // Divide 32 by 16
    ld(32'h12345678);
    core.wr(`MD_ADDR_OPERAND_4, 8'h00);
    core.wr(`MD_ADDR_OPERAND_5, 8'h01);
    wait_done();
    rd32(v);
    chk("quotient32", 32'h00123456, v);
    core.rd(`MD_ADDR_OPERAND_4, b);
    core.rd(`MD_ADDR_OPERAND_5, h);
    chk("remainder32", 32'h78, {16'h0, h, b});
    core.rd(`MD_ADDR_CONTROL, b);
    chk("flags div32", 32'h0, {30'h0, b[7:6]});
    // Divide 16 by 16 by zero, then by 0x0010
    for (int k = 0; k < 2; k++) begin
      core.wr(`MD_ADDR_OPERAND_0, 8'h34);
      core.wr(`MD_ADDR_OPERAND_1, 8'h12);
      core.wr(`MD_ADDR_OPERAND_4, k[0] ? 8'h10 : 8'h00);
      core.wr(`MD_ADDR_OPERAND_5, 8'h00);
      wait_done();
      core.rd(`MD_ADDR_CONTROL, b);
      chk("overflow div16", {31'h0, ~k[0]}, {31'h0, b[`MD_BIT_OVERFLOW]});
    end
    rd32(v);
    chk("quotient16", 32'h0123, v[15:0]);
    core.rd(`MD_ADDR_OPERAND_4, b);
    chk("remainder16", 32'h4, {24'h0, b});
    // Shift both ways, boundary counts, then normalize
    for (int k = 0; k < 6; k++) begin
      ld(sh_in[k]);
      core.wr(`MD_ADDR_CONTROL, sh_ctl[k]);
      wait_done();
      rd32(v);
      chk("shift result", sh_out[k], v);
    end
    core.rd(`MD_ADDR_CONTROL, b);
    chk("normalize count", 32'h13, {27'h0, b[`MD_COUNT_MSB:0]});
    // Restart a running divide
    ld(32'hffff0000);
    core.wr(`MD_ADDR_OPERAND_4, 8'h03);
    core.wr(`MD_ADDR_OPERAND_5, 8'h00);
    core.wr(`MD_ADDR_OPERAND_5, 8'h00);
    wait_done();
    core.rd(`MD_ADDR_CONTROL, b);
    chk("error flag", 32'h1, {31'h0, b[`MD_BIT_ERROR]});
    results();
  end
endmodule : muldiv_coprocessor_sfr_tb
`default_nettype wire
